// *** hw/tfr_pkg.sv ***
// Function
// R1: select register bits 7 and 5 read one
// R2: select bit 6 picks block addressing
// R3: block address built from four registers
// R4: select bit 4 picks drive zero/one
// R5: select bits 3-0 hold head nibble
// R6: primary status read clears interrupt; alternate not
// R7: host reads primary status bytewise
// R8: busy refuses host command and buffer access
// R9: ready clear at power up until able
// R10: bit 5 write fault, bit 4 seek complete
// R11: data request set, cleared by next command
// R12: bit 2 corrected error, read continues
// R13: index bit always reads zero
// R14: error bit, cleared by next command
// R15: device control writable even while busy
// R16: soft reset bit holds card in reset
// R17: control bit 1 disables interrupt output
// R18: host writes zeros to control bits 7-3
// R19: address bit 6 low while writing
// R20: address bits 5-2 invert head nibble
// R21: address bits 1-0 low for selected drive
// R22: host avoids mapping drive address register; the adapter passes offset 4'hf through
// R23: select register reads back written bits
package tfr_pkg;
   localparam logic [3:0] TFR_OFS_SELECT = 4'h6;
   localparam logic [3:0] TFR_OFS_STATUS = 4'h7;
   localparam logic [3:0] TFR_OFS_ALTCTL = 4'he;
   localparam logic [3:0] TFR_OFS_DRVADR = 4'hf;
   localparam int TFR_SEL_ONE7 = 7;
   localparam int TFR_SEL_LBA = 6;
   localparam int TFR_SEL_ONE5 = 5;
   localparam int TFR_SEL_DRV = 4;
   localparam int TFR_ST_BUSY = 7;
   localparam int TFR_ST_RDY = 6;
   localparam int TFR_ST_WF = 5;
   localparam int TFR_ST_DSC = 4;
   localparam int TFR_ST_DRQ = 3;
   localparam int TFR_ST_CORRECTED_ERROR_FLAG = 2;
   localparam int TFR_ST_IDX = 1;
   localparam int TFR_ST_ERR = 0;
   localparam int TFR_DC_SRST = 2;
   localparam int TFR_DC_IDIS = 1;
   localparam int TFR_DA_WTG = 6;
   // head nibble in select and its inverted copy in the drive address
   localparam int TFR_SEL_NIB_HI = 3;
   localparam int TFR_SEL_NIB_LO = 0;
   localparam int TFR_DA_NIB_HI = 5;
   localparam int TFR_DA_NIB_LO = 2;
   localparam int TFR_DA_DS1 = 1;
   localparam int TFR_DA_DS0 = 0;
   // adapter command word read flag and control bits forced to zero
   localparam int TFR_CMD_RD = 8;
   localparam int TFR_DC_ZERO_HI = 7;
   localparam int TFR_DC_ZERO_LO = 3;
   // adapter status word busy flag
   localparam int TFR_STAT_BUSY = 0;
   localparam logic [7:0] TFR_SEL_RESET = 8'ha0;
   localparam logic [7:0] TFR_DIAG_CODE = 8'h01;
   localparam logic [7:0] TFR_BYTE_ZERO = 8'h00;
   // apb register byte offsets of the host adapter
   localparam logic [7:0] TFR_APB_CMD = 8'h00;
   localparam logic [7:0] TFR_APB_WDATA = 8'h04;
   localparam logic [7:0] TFR_APB_RDATA = 8'h08;
   localparam logic [7:0] TFR_APB_STAT = 8'h0c;
endpackage : tfr_pkg

// *** hw/tfr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// parallel task-file register bus between host adapter and card
interface tfr_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rd;
   logic wr;
   logic interrupt_request_out_n;
   modport card (input addr, input wdata, input rd, input wr, output rdata,
      output interrupt_request_out_n);
   modport host (output addr, output wdata, output rd, output wr, input rdata,
      input interrupt_request_out_n);
endinterface : tfr_if
`default_nettype wire

// *** hw/tfr_card.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfr_card (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // task-file bus
   tfr_if.card bus,
   // card core side
   input wire logic copy_is_drive1,
   input wire logic core_ready,
   input wire logic core_busy,
   input wire logic cmd_start,
   input wire logic ev_write_fault,
   input wire logic ev_drq,
   input wire logic ev_corrected,
   input wire logic ev_error,
   input wire logic ev_done,
   input wire logic write_active,
   input wire logic [7:0] sector_number,
   input wire logic [7:0] cyl_low,
   input wire logic [7:0] cyl_high,
   output logic lba_mode,
   output logic [27:0] block_address,
   output logic soft_reset,
   output logic [7:0] error_code,
   output logic [7:0] status_out
);
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] st;
      logic srst;
      logic idis;
      logic irq;
      logic [7:0] err;
      logic [7:0] rd;
      logic irq_n;
   } tfr_card_state_t;
   // local names for the field positions shared with the package
   localparam int TFR_SEL_DRV = tfr_pkg::TFR_SEL_DRV;
   localparam int TFR_SEL_LBA = tfr_pkg::TFR_SEL_LBA;
   localparam int TFR_SEL_ONE7 = tfr_pkg::TFR_SEL_ONE7;
   localparam int TFR_SEL_ONE5 = tfr_pkg::TFR_SEL_ONE5;
   localparam int TFR_ST_IDX = tfr_pkg::TFR_ST_IDX;
   localparam int TFR_ST_BUSY = tfr_pkg::TFR_ST_BUSY;
   localparam int TFR_ST_RDY = tfr_pkg::TFR_ST_RDY;
   localparam int TFR_ST_DSC = tfr_pkg::TFR_ST_DSC;
   localparam int TFR_ST_DRQ = tfr_pkg::TFR_ST_DRQ;
   localparam int TFR_ST_ERR = tfr_pkg::TFR_ST_ERR;
   localparam int TFR_ST_WF = tfr_pkg::TFR_ST_WF;
   localparam int TFR_ST_CORRECTED_ERROR_FLAG = tfr_pkg::TFR_ST_CORRECTED_ERROR_FLAG;
   localparam int TFR_DA_WTG = tfr_pkg::TFR_DA_WTG;
   // head nibble in select and its inverted copy in the drive address
   localparam int TFR_SEL_NIB_HI = tfr_pkg::TFR_SEL_NIB_HI;
   localparam int TFR_SEL_NIB_LO = tfr_pkg::TFR_SEL_NIB_LO;
   localparam int TFR_DA_NIB_HI = tfr_pkg::TFR_DA_NIB_HI;
   localparam int TFR_DA_NIB_LO = tfr_pkg::TFR_DA_NIB_LO;
   // drive address select flags, low for the active drive
   localparam int TFR_DA_DS1 = tfr_pkg::TFR_DA_DS1;
   localparam int TFR_DA_DS0 = tfr_pkg::TFR_DA_DS0;
   tfr_card_state_t s, next_s;
   // the selected drive matches this copy's drive number
   logic selected;
   // status as the host sees it, index forced low
   logic [7:0] stv;
   // next state of the card registers and the read mux
   always_comb
   begin
      // hold every field unless an event below changes it
      next_s = s;
      // R4: drive number compared to copy
      selected = s.sel[TFR_SEL_DRV] == copy_is_drive1;
      stv = s.st;
      // R13: index reads zero
      stv[TFR_ST_IDX] = 1'b0;
      // R1: fixed ones
      next_s.sel[TFR_SEL_ONE7] = 1'b1;
      next_s.sel[TFR_SEL_ONE5] = 1'b1;
      // device control is write only; reads here see alternate status
      // R15: control write always accepted
      if (bus.wr && bus.addr == tfr_pkg::TFR_OFS_ALTCTL)
      begin
         // R16: soft reset while bit set
         next_s.srst = bus.wdata[tfr_pkg::TFR_DC_SRST];
         // R17: interrupt disable
         next_s.idis = bus.wdata[tfr_pkg::TFR_DC_IDIS];
      end
      // a refused write leaves the select register untouched
      // R8: select write refused while busy
      if (bus.wr && bus.addr == tfr_pkg::TFR_OFS_SELECT && !s.st[TFR_ST_BUSY])
      begin
         // R23: keep written bits
         next_s.sel = bus.wdata | tfr_pkg::TFR_SEL_RESET;
      end
      // R9: ready follows core
      next_s.st[TFR_ST_RDY] = core_ready;
      // R10: seek complete with ready
      next_s.st[TFR_ST_DSC] = core_ready;
      // R8: busy follows core
      next_s.st[TFR_ST_BUSY] = core_busy;
      // a new command clears the sticky flags
      if (cmd_start)
      begin
         // R11: next command clears
         next_s.st[TFR_ST_DRQ] = 1'b0;
         // R14: next command clears
         next_s.st[TFR_ST_ERR] = 1'b0;
         next_s.st[TFR_ST_WF] = 1'b0;
         next_s.st[TFR_ST_CORRECTED_ERROR_FLAG] = 1'b0;
      end
      // events after the clears so a set in the same cycle wins
      // R10: write fault
      if (ev_write_fault)
         next_s.st[TFR_ST_WF] = 1'b1;
      // R11: data request from core
      if (ev_drq)
         next_s.st[TFR_ST_DRQ] = 1'b1;
      // R12: corrected, no abort
      if (ev_corrected)
         next_s.st[TFR_ST_CORRECTED_ERROR_FLAG] = 1'b1;
      // R14: error from core
      if (ev_error)
         next_s.st[TFR_ST_ERR] = 1'b1;
      // R6: primary read clears pending
      if (bus.rd && bus.addr == tfr_pkg::TFR_OFS_STATUS)
         next_s.irq = 1'b0;
      // completion wins over a clearing read in the same cycle
      if (ev_done)
         next_s.irq = 1'b1;
      // R16: status cleared, diag written
      // held clear every cycle while the reset bit stands
      if (s.srst)
      begin
         next_s.st = tfr_pkg::TFR_BYTE_ZERO;
         next_s.err = tfr_pkg::TFR_DIAG_CODE;
         next_s.irq = 1'b0;
      end
      // read mux
      // the byte is latched and stands from the next cycle
      case (bus.addr)
         tfr_pkg::TFR_OFS_SELECT: next_s.rd = s.sel;
         // R6: alternate returns same bits
         tfr_pkg::TFR_OFS_STATUS, tfr_pkg::TFR_OFS_ALTCTL: next_s.rd = stv;
         tfr_pkg::TFR_OFS_DRVADR:
         begin
            // bit 7 is undefined; it is driven low
            next_s.rd = tfr_pkg::TFR_BYTE_ZERO;
            // R19: write in progress low
            next_s.rd[TFR_DA_WTG] = !write_active;
            // R20: inverted head nibble
            next_s.rd[TFR_DA_NIB_HI:TFR_DA_NIB_LO] = ~s.sel[TFR_SEL_NIB_HI:TFR_SEL_NIB_LO];
            // R21: selected drive low
            next_s.rd[TFR_DA_DS1] = !(selected && s.sel[TFR_SEL_DRV]);
            next_s.rd[TFR_DA_DS0] = !(selected && !s.sel[TFR_SEL_DRV]);
         end
         // unmapped offsets read as zero
         default: next_s.rd = tfr_pkg::TFR_BYTE_ZERO;
      endcase
      // R17: gate request output
      // registered so the request pin comes straight from a flip-flop
      next_s.irq_n = !(next_s.irq && !next_s.idis && selected);
   end
   // state and core-side outputs, asynchronous reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // R1: select resets with the fixed ones
         s.sel <= tfr_pkg::TFR_SEL_RESET;
         // R9: ready clear at power up
         s.st <= tfr_pkg::TFR_BYTE_ZERO;
         s.srst <= 1'b0;
         // R17: interrupts enabled at power on
         s.idis <= 1'b0;
         s.irq <= 1'b0;
         s.err <= tfr_pkg::TFR_BYTE_ZERO;
         s.rd <= tfr_pkg::TFR_BYTE_ZERO;
         s.irq_n <= 1'b1;
         // core side outputs start idle
         lba_mode <= 1'b0;
         block_address <= 28'h0000000;
         soft_reset <= 1'b0;
         error_code <= tfr_pkg::TFR_BYTE_ZERO;
         status_out <= tfr_pkg::TFR_BYTE_ZERO;
      end
      else
      begin
         // core outputs follow the next state so they line up with s
         s <= next_s;
         // R2: addressing mode
         lba_mode <= next_s.sel[TFR_SEL_LBA];
         // R3: block address assembly
         // R5: head nibble on top
         block_address <= {next_s.sel[TFR_SEL_NIB_HI:TFR_SEL_NIB_LO], cyl_high, cyl_low,
            sector_number};
         // R16: reset level to the core
         soft_reset <= next_s.srst;
         // R16: diagnostic code to the core
         error_code <= next_s.err;
         // status copy for the core
         status_out <= next_s.st;
      end
   end
   // bus outputs straight from the state flops
   assign bus.rdata = s.rd;
   assign bus.interrupt_request_out_n = s.irq_n;
endmodule : tfr_card
`default_nettype wire

// *** hw/tfr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfr_host (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // task-file bus
   tfr_if.host bus
);
   typedef enum logic [1:0] {
      TFR_H_IDLE = 2'b00,
      TFR_H_STROBE = 2'b01,
      TFR_H_DONE = 2'b11
   } tfr_host_phase_t;
   typedef struct packed {
      tfr_host_phase_t ph;
      logic [3:0] addr;
      logic [7:0] wd;
      logic [7:0] rdv;
      logic rd;
      logic wr;
      logic is_rd;
      logic [31:0] prd;
      logic rdy;
      logic err;
   } tfr_host_state_t;
   tfr_host_state_t s, next_s;
   logic acc;
   // apb decode and task-file strobe sequencing
   always_comb
   begin
      next_s = s;
      acc = psel && penable && !s.rdy;
      next_s.rdy = 1'b0;
      next_s.err = 1'b0;
      next_s.rd = 1'b0;
      next_s.wr = 1'b0;
      case (s.ph)
         TFR_H_IDLE:
         begin
            if (acc && pwrite && paddr == tfr_pkg::TFR_APB_CMD)
            begin
               // cmd word: bit 8 read, bits 3-0 offset
               next_s.addr = pwdata[3:0];
               next_s.is_rd = pwdata[tfr_pkg::TFR_CMD_RD];
               // R18: control bits 7-3 written as zero
               if (pwdata[3:0] == tfr_pkg::TFR_OFS_ALTCTL && !pwdata[tfr_pkg::TFR_CMD_RD])
                  next_s.wd[tfr_pkg::TFR_DC_ZERO_HI:tfr_pkg::TFR_DC_ZERO_LO] = '0;
               next_s.rd = pwdata[tfr_pkg::TFR_CMD_RD];
               next_s.wr = !pwdata[tfr_pkg::TFR_CMD_RD];
               next_s.ph = TFR_H_STROBE;
               next_s.rdy = 1'b1;
            end
            else if (acc && pwrite && paddr == tfr_pkg::TFR_APB_WDATA)
            begin
               next_s.wd = pwdata[7:0];
               next_s.rdy = 1'b1;
            end
            else if (acc)
            begin
               next_s.rdy = 1'b1;
               next_s.err = pwrite;
               case (paddr)
                  tfr_pkg::TFR_APB_RDATA: next_s.prd = {24'h000000, s.rdv};
                  tfr_pkg::TFR_APB_STAT:
                     next_s.prd = {30'h0, bus.interrupt_request_out_n, 1'b0};
                  default:
                  begin
                     next_s.prd = 32'h00000000;
                     next_s.err = 1'b1;
                  end
               endcase
            end
         end
         TFR_H_STROBE: next_s.ph = TFR_H_DONE;
         TFR_H_DONE:
         begin
            // R7: status taken as one byte
            if (s.is_rd)
               next_s.rdv = bus.rdata;
            next_s.ph = TFR_H_IDLE;
         end
         default: next_s.ph = TFR_H_IDLE;
      endcase
      // busy phase shows in status bit 0
      if (acc && paddr == tfr_pkg::TFR_APB_STAT && s.ph == TFR_H_IDLE)
         next_s.prd[tfr_pkg::TFR_STAT_BUSY] = 1'b0;
      else if (acc && paddr == tfr_pkg::TFR_APB_STAT)
         next_s.prd[tfr_pkg::TFR_STAT_BUSY] = 1'b1;
   end
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
   assign prdata = s.prd;
   assign pready = s.rdy;
   assign pslverr = s.err;
   assign bus.addr = s.addr;
   assign bus.wdata = s.wd;
   assign bus.rd = s.rd;
   assign bus.wr = s.wr;
endmodule : tfr_host
`default_nettype wire

// *** tb/tfr_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfr_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // task-file bus
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rd,
   input wire logic wr,
   input wire logic interrupt_request_out_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_sel_q;
   logic nib_ok;
   logic srst;
   logic [3:0] nib;
   // keep the select nibble seen on readback and the soft reset bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_sel_q <= 1'b0;
         nib_ok <= 1'b0;
         nib <= 4'h0;
         srst <= 1'b0;
      end
      else
      begin
         rd_sel_q <= rd && addr == tfr_pkg::TFR_OFS_SELECT;
         if (rd_sel_q)
         begin
            nib <= rdata[3:0];
            nib_ok <= 1'b1;
         end
         // a later write may change the nibble, so forget it
         if (wr && (addr == tfr_pkg::TFR_OFS_SELECT || addr == tfr_pkg::TFR_OFS_ALTCTL))
            nib_ok <= 1'b0;
         if (wr && addr == tfr_pkg::TFR_OFS_ALTCTL)
            srst <= wdata[tfr_pkg::TFR_DC_SRST];
      end
   end
   sel_ones_a: assert property (rd && addr == tfr_pkg::TFR_OFS_SELECT |=>
      rdata[7] && rdata[5]) else $error("select bits 7 and 5 not one");
   idx_zero_a: assert property (rd && (addr == tfr_pkg::TFR_OFS_STATUS ||
      addr == tfr_pkg::TFR_OFS_ALTCTL) |=> !rdata[1]) else $error("index bit set");
   drvadr_inv_a: assert property (nib_ok && rd && addr == tfr_pkg::TFR_OFS_DRVADR |=>
      rdata[5:2] == ~nib) else $error("drive address nibble not inverted");
   srst_clear_a: assert property (srst && rd && addr == tfr_pkg::TFR_OFS_STATUS |=>
      rdata == 8'h00) else $error("status not clear in soft reset");
   irq_disable_a: assert property (wr && addr == tfr_pkg::TFR_OFS_ALTCTL && wdata[1]
      ##1 (!(wr && addr == tfr_pkg::TFR_OFS_ALTCTL))[*3] |-> interrupt_request_out_n)
      else $error("interrupt seen while disabled");
   rd_pulse_a: assert property (rd |=> !rd) else $error("read strobe too long");
   wr_pulse_a: assert property (wr |=> !wr) else $error("write strobe too long");
   rd_wr_excl_a: assert property (!(rd && wr)) else $error("read and write together");
   cover property (rd && addr == tfr_pkg::TFR_OFS_DRVADR);
   cover property ($fell(interrupt_request_out_n));
   cover property (srst && rd && addr == tfr_pkg::TFR_OFS_STATUS);
endmodule : tfr_sva
`default_nettype wire

// *** tb/ata_task_file_select_status_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_select_status_control_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic copy_is_drive1, core_ready, core_busy, write_active, lba_mode, soft_reset;
   logic [5:0] ev;
   logic [7:0] paddr, error_code, status_out, q;
   logic [7:0] sec_no, cyl_lo, cyl_hi;
   logic [27:0] block_address;
   logic [31:0] pwdata, prdata, x;
   int n_errors, comparisons, cyc;
   tfr_if tfr_if_i ();
   tfr_host tfr_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(tfr_if_i));
   tfr_card tfr_card_i (.pclk(pclk), .presetn(presetn), .bus(tfr_if_i),
      .copy_is_drive1(copy_is_drive1), .core_ready(core_ready), .core_busy(core_busy),
      .cmd_start(ev[5]), .ev_write_fault(ev[4]), .ev_drq(ev[3]), .ev_corrected(ev[2]),
      .ev_error(ev[1]), .ev_done(ev[0]), .write_active(write_active),
      .sector_number(sec_no), .cyl_low(cyl_lo), .cyl_high(cyl_hi), .lba_mode(lba_mode),
      .block_address(block_address), .soft_reset(soft_reset), .error_code(error_code),
      .status_out(status_out));
   tfr_sva tfr_sva_i (.pclk(pclk), .presetn(presetn), .addr(tfr_if_i.addr),
      .wdata(tfr_if_i.wdata), .rdata(tfr_if_i.rdata), .rd(tfr_if_i.rd), .wr(tfr_if_i.wr),
      .interrupt_request_out_n(tfr_if_i.interrupt_request_out_n));
   // one apb transfer, held until pready; result left in x and e
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      x = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one task-file access through the adapter; read byte left in q
   task tf(input logic r, input logic [3:0] o, input logic [7:0] d);
      int n;
      n = 0;
      apb(1'b1, tfr_pkg::TFR_APB_WDATA, 32'(d));
      apb(1'b1, tfr_pkg::TFR_APB_CMD, {23'h0, r, 4'h0, o});
      repeat (3) @(posedge pclk);
      do
      begin
         apb(1'b0, tfr_pkg::TFR_APB_STAT, 32'h0);
         n++;
      end
      while (x[0] !== 1'b0 && n < 50);
      if (x[0] !== 1'b0)
      begin
         $display("[ERR] adapter idle expected 0 seen %b", x[0]);
         n_errors++;
      end
      apb(1'b0, tfr_pkg::TFR_APB_RDATA, 32'h0);
      q = x[7:0];
   endtask : tf
   task chk(input string s, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", s, exp, got);
         n_errors++;
      end
   endtask : chk
   // one-cycle core events: {start, fault, drq, corrected_error_flag, err, done}
   task pulse(input logic [5:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 6'h00;
   endtask : pulse
   task t_status;
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("status at reset", 32'h00, 32'(q));
      core_ready <= 1'b1;
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("status ready", 32'h50, 32'(q));
      pulse(6'b011110);
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("status events", 32'h7d, 32'(q));
      chk("status out", 32'h7d, 32'(status_out));
      tf(1'b1, tfr_pkg::TFR_OFS_ALTCTL, 8'h00);
      chk("alt status", 32'h7d, 32'(q));
      pulse(6'b100000);
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("drq err cleared", 32'h00, 32'(q & 8'h09));
      core_busy <= 1'b1;
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("busy bit", 32'h1, 32'(q[7]));
      tf(1'b0, tfr_pkg::TFR_OFS_SELECT, 8'h0f);
      tf(1'b1, tfr_pkg::TFR_OFS_SELECT, 8'h00);
      chk("select while busy", 32'ha0, 32'(q));
      tf(1'b0, tfr_pkg::TFR_OFS_ALTCTL, 8'h04);
      chk("soft reset on", 32'h1, 32'(soft_reset));
      chk("diag code", 32'h01, 32'(error_code));
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("status in reset", 32'h00, 32'(q));
      core_busy <= 1'b0;
      tf(1'b0, tfr_pkg::TFR_OFS_ALTCTL, 8'h00);
      chk("soft reset off", 32'h0, 32'(soft_reset));
      $display("status test done");
   endtask : t_status
   task t_select;
      tf(1'b0, tfr_pkg::TFR_OFS_SELECT, 8'h5f);
      tf(1'b1, tfr_pkg::TFR_OFS_SELECT, 8'h00);
      chk("select lba", 32'hff, 32'(q));
      chk("lba mode", 32'h1, 32'(lba_mode));
      chk("block addr", 32'h0f563412, 32'(block_address));
      tf(1'b0, tfr_pkg::TFR_OFS_SELECT, 8'h03);
      tf(1'b1, tfr_pkg::TFR_OFS_SELECT, 8'h00);
      chk("select chs", 32'ha3, 32'(q));
      chk("chs mode", 32'h0, 32'(lba_mode));
      tf(1'b1, tfr_pkg::TFR_OFS_DRVADR, 8'h00);
      chk("drive addr 0", 32'h72, 32'(q));
      copy_is_drive1 <= 1'b1;
      write_active <= 1'b1;
      tf(1'b0, tfr_pkg::TFR_OFS_SELECT, 8'h10);
      tf(1'b1, tfr_pkg::TFR_OFS_DRVADR, 8'h00);
      chk("drive addr 1", 32'h3d, 32'(q));
      copy_is_drive1 <= 1'b0;
      write_active <= 1'b0;
      tf(1'b0, tfr_pkg::TFR_OFS_SELECT, 8'h00);
      $display("select test done");
   endtask : t_select
   task t_irq;
      pulse(6'b000001);
      repeat (3) @(posedge pclk);
      chk("irq raised", 32'h0, 32'(tfr_if_i.interrupt_request_out_n));
      tf(1'b1, tfr_pkg::TFR_OFS_ALTCTL, 8'h00);
      chk("irq after alt", 32'h0, 32'(tfr_if_i.interrupt_request_out_n));
      tf(1'b1, tfr_pkg::TFR_OFS_STATUS, 8'h00);
      chk("irq after status", 32'h1, 32'(tfr_if_i.interrupt_request_out_n));
      tf(1'b0, tfr_pkg::TFR_OFS_ALTCTL, 8'h02);
      pulse(6'b000001);
      repeat (3) @(posedge pclk);
      chk("irq masked", 32'h1, 32'(tfr_if_i.interrupt_request_out_n));
      apb(1'b0, tfr_pkg::TFR_APB_STAT, 32'h0);
      chk("stat irq bit", 32'h1, 32'(x[1]));
      tf(1'b0, tfr_pkg::TFR_OFS_ALTCTL, 8'h00);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, 32'(e));
      apb(1'b1, tfr_pkg::TFR_APB_RDATA, 32'h0);
      chk("ro write err", 32'h1, 32'(e));
      $display("interrupt test done");
   endtask : t_irq
   task conclude;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_errors++;
         conclude();
      end
   end
   // reset, then the tests in order
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {copy_is_drive1, core_ready, core_busy, write_active, ev} = '0;
      sec_no = 8'h12;
      cyl_lo = 8'h34;
      cyl_hi = 8'h56;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_status();
      t_select();
      t_irq();
      conclude();
   end
endmodule : ata_task_file_select_status_control_tb_top
`default_nettype wire
